// >>> bench/scs_config_store_checker.sv
// port assertions for the configuration store
`timescale 1ns/1ns
module scs_config_store_checker #(
  parameter int unsigned CYC_PER_MS = 10 // cycles per millisecond
) (
  input wire logic clk, rst_n, sample_valid, refresh_tick, frame_valid, // clock, strobes
  input wire logic out_digital, out_with_temp, out_analog_abs, out_analog_ratio, // format
  input wire logic reg_enable, reg_high,  // regulator decode
  input wire logic [5:0] preamp_gain,     // gain value
  input wire logic [1:0] frame_len,       // frame byte count
  input wire logic [8:0] frame_byte0      // bridge high byte
);
  int unsigned gap;
  // cycles since the last tick; a delay range would be far too long here
  always_ff @(posedge clk) gap <= (!rst_n || refresh_tick) ? 0 : gap + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  fmt_excl_a: assert property (out_analog_abs |-> !(out_digital || out_analog_ratio))
    else $error("analog formats overlap");
  temp_dig_a: assert property (out_with_temp |-> out_digital)
    else $error("temp byte in analog");
  frame_resp_a: assert property (sample_valid |=> frame_valid == $past(out_digital))
    else $error("frame response wrong");
  frame_len_a: assert property (sample_valid && out_digital |=>
    frame_len == ($past(out_with_temp) ? 2'd3 : 2'd2)) else $error("frame length wrong");
  frame_hi_a: assert property (frame_valid |-> frame_byte0[7:6] == 2'b00 && !(^frame_byte0))
    else $error("high byte bad");
  reg_cfg_a: assert property (reg_high |-> reg_enable)
    else $error("high regulation without enable");
  tick_gap_a: assert property (refresh_tick |=> !refresh_tick [*8])
    else $error("ticks too close");
  tick_due_a: assert property (gap < CYC_PER_MS * 125)
    else $error("refresh tick overdue");
  gain_set_a: assert property (preamp_gain inside {6'd6, 6'd12, 6'd24, 6'd48})
    else $error("preamp gain illegal");
  cover property (frame_valid && frame_len == 2'd3);
  cover property (frame_valid && frame_len == 2'd2);
  cover property (reg_high);
endmodule // scs_config_store_checker
bind scs_config_store scs_config_store_checker #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.*);

// >>> bench/scs_config_store_tb_top.sv
// self-checking testbench for the configuration store
`timescale 1ns/1ns
module scs_config_store_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, sample_valid = 1'b0, cmd_valid, refresh_tick;
  logic        cfg_ready, out_digital, out_with_temp, out_analog_abs, out_analog_ratio;
  logic        reg_enable, reg_high, bridge_invert, frame_valid;
  logic [2:0]  rd_index = 3'h1;
  logic [15:0] cmd_word, rd_data;
  logic [13:0] bridge = 14'h0000;
  logic [5:0]  preamp_gain;
  logic [1:0]  frame_len;
  logic [8:0]  frame_byte0, frame_byte1, frame_byte2;
  logic signed [3:0] osc_step;
  logic signed [4:0] window_low;
  int          error_cnt = 0, total_checks = 0, n;
  scs_config_store #(.CYC_PER_MS(10)) dut_u (.clk, .rst_n, .cmd_valid, .cmd_word,
    .coef_wr_valid(1'b0), .coef_wr_index(3'h0), .coef_wr_data(16'h0000), .rd_index, .rd_data,
    .cfg_ready, .refresh_tick, .osc_step, .vref_adjust(), .window_low, .out_digital,
    .out_with_temp, .out_analog_abs, .out_analog_ratio, .reg_enable, .reg_high, .bridge_invert,
    .span_x8(), .span_frac(), .bridge_zero(), .temp_span(), .temp_zero(), .temp_ref(),
    .span_tc(), .zero_tc(), .sot_bridge(), .sot_span_tc(), .sot_zero_tc(), .preamp_gain,
    .sample_valid, .bridge_sample(bridge), .temp_sample(8'h3C), .frame_valid, .frame_len,
    .frame_byte0, .frame_byte1, .frame_byte2);
  scs_host_model host_u (.clk, .cmd_valid, .cmd_word);
  always #20 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // cycles to next tick; no tick ends the run
  task automatic wait_tick(output int c);
    c = 0;
    do begin @(posedge clk); #1 c++; end while (refresh_tick !== 1'b1 && c < 2000);
    if (c >= 2000) begin chk(16'h0001, 16'h0000); conclude(); end
  endtask
  task automatic t_reset;
    repeat (2) @(posedge clk);
    #1 chk(cfg_ready, 16'h0001);
    chk(rd_data, 16'h0400);
    chk(preamp_gain, 16'd24);
    chk({out_digital, out_with_temp, out_analog_abs, out_analog_ratio}, 16'hC);
  endtask
  // all oscillator, window, format, regulator and gain codes, junk in unused bits
  task automatic t_codes;
    logic [3:0] f;
    for (int i = 0; i < 8; i++) begin
      host_u.cfg_write(4'h0, {1'b1, i[2:0]});
      host_u.cfg_write(4'h2, {2'b11, i[1:0]});
      host_u.cfg_write(4'h3, {2'b11, i[1:0]});
      host_u.cfg_write(4'h5, {2'b11, i[1:0]});
      host_u.cfg_write(4'h6, {i[0], 3'b000});
      host_u.cfg_write(4'h7, {2'b00, i[1:0]});
      wait_tick(n);
      repeat (2) @(posedge clk);
      #1 f = 16'h812C >> (4 * i[1:0]);
      chk({osc_step}, {4'h0 - {i[2], i[2:0]}});
      chk({window_low}, {5'h0 - (5'h1 << i[1:0])});
      chk({out_digital, out_with_temp, out_analog_abs, out_analog_ratio}, f);
      chk({reg_enable, reg_high}, 8'hE0 >> (2 * i[1:0]) & 2'b11);
      chk(preamp_gain, {6'd48, 6'd12, 6'd24, 6'd6} >> (6 * i[1:0]) & 6'h3F);
      chk(bridge_invert, i[0]);
      @(posedge clk);
      #1 sample_valid = 1'b1;
      bridge = {i[2:0], 11'h2A5};
      @(posedge clk);
      #1 sample_valid = 1'b0;
      chk(frame_valid, f[3]);
      if (f[3]) begin
        chk(frame_len, f[2] ? 16'd3 : 16'd2);
        chk(frame_byte0, {^bridge[13:8], 2'b00, bridge[13:8]});
        chk(frame_byte1, {^bridge[7:0], bridge[7:0]});
        chk(frame_byte2, f[2] ? 16'h003C : 16'h0000);
      end
    end
  endtask
  // one full period per rate
  task automatic t_rate;
    int per [4] = '{10, 50, 250, 1250};
    for (int r = 0; r < 4; r++) begin
      host_u.cfg_write(4'h4, 4'(r));
      repeat (3) wait_tick(n);
      chk(16'(n), 16'(per[r]));
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_codes();
    t_rate();
    conclude();
  end
endmodule // scs_config_store_tb_top

// >>> bench/scs_host_model.sv
// calibration host issuing configuration-write commands
`timescale 1ns/1ns
module scs_host_model (
  input wire logic   clk,       // system clock
  output logic       cmd_valid = 1'b0, // command strobe
  output logic [15:0] cmd_word = 16'h0000 // command word
);
  // route code 11 is never sent, folded to 10
  task automatic cfg_write(input logic [3:0] fld, input logic [3:0] dat);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_word = {8'h30, fld, (fld == 4'h7 && dat[3:2] == 2'b11) ? {2'b10, dat[1:0]} : dat};
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    cmd_word = ~cmd_word; // no stale command
  endtask
endmodule // scs_host_model

// >>> rtl/scs_config_store.sv
// configuration and coefficient store with field decoding
// Behaviour
// RQ1: oscillator adjust code maps to signed speed steps, 100 fastest, 011 slowest
// RQ2: converter offset code sets bridge input window lower bound in sixteenths
// RQ3: top bit of compensation options inverts bridge signal polarity
// RQ4: format 00 gives three parity bytes: bridge high, bridge low, temperature
// RQ5: format 01 gives absolute 0-1 V analog, 10 ratiometric analog
// RQ6: format 11 gives only the two parity bridge bytes
// RQ7: update rate code sets refresh period 1, 5, 25 or 125 ms
// RQ8: regulator code 0x disables, 10 regulates at 5.0 V, 11 at 5.5 V
// RQ9: bridge span in bits 29:15, top bit multiplies the rest by 8
// RQ10: lower fourteen span bits are unsigned fixed point in [0,8)
// RQ11: bridge offset in bits 43:30, signed fourteen bits
// RQ12: temperature span in bits 51:44 scales the temperature sensor
// RQ13: temperature offset in bits 59:52 corrects the temperature sensor
// RQ14: bits 67:60 hold raw temperature reference value
// RQ15: span temperature coefficient in 75:68, option bit 2 makes it negative
// RQ16: offset temperature coefficient in 83:76, option bit 0 makes it negative
// RQ17: option bit 1 scales offset coefficient, and routed quadratic term, by 8
// RQ18: quadratic term in 95:88 is sign-magnitude, bit 7 negative
// RQ19: bits 99:98 route quadratic term; host never writes 11
// RQ20: bits 97:96 select preamplifier gain 6, 24, 12 or 48
// RQ21: config command third nibble selects field, oscillator keeps three bits
// RQ22: load working settings after reset, apply writes by next update period
`timescale 1ns/1ns
`include "scs_params.svh"
module scs_config_store #(
  parameter int unsigned CYC_PER_MS = `SCS_CLK_MHZ * `SCS_BASE_PERIOD_US,
  parameter bit          PARITY_ODD = 1'b0
) (
  input  wire logic         clk,             // 25 MHz trimmed oscillator
  input  wire logic         rst_n,           // synchronous reset, active low
  input  wire logic         cmd_valid,       // serial decoder command strobe
  input  wire logic [15:0]  cmd_word,        // command word, four nibbles
  input  wire logic         coef_wr_valid,   // whole-word store write strobe
  input  wire logic [2:0]   coef_wr_index,   // store word index 0..6
  input  wire logic [15:0]  coef_wr_data,    // store word data
  input  wire logic [2:0]   rd_index,        // store word read index
  output logic [15:0]       rd_data,         // store word read data
  output logic              cfg_ready,       // working settings loaded
  output logic              refresh_tick,    // start of an update period
  output logic signed [3:0] osc_step,        // speed steps vs nominal
  output logic [3:0]        vref_adjust,     // reference voltage adjust
  output logic signed [4:0] window_low,      // window lower bound, 1/16 units
  output logic              out_digital,     // digital serial output mode
  output logic              out_with_temp,   // digital frame carries temp
  output logic              out_analog_abs,  // absolute 0-1 V output
  output logic              out_analog_ratio,// ratiometric analog output
  output logic              reg_enable,      // external regulation on
  output logic              reg_high,        // regulate at 5.5 V, else 5.0 V
  output logic              bridge_invert,   // bridge polarity flipped
  output logic              span_x8,         // bridge span multiplied by 8
  output logic [13:0]       span_frac,       // span, 3.11 unsigned fixed
  output logic signed [13:0] bridge_zero,    // bridge offset
  output logic [7:0]        temp_span,       // temperature span
  output logic [7:0]        temp_zero,       // temperature offset
  output logic [7:0]        temp_ref,        // raw temperature reference
  output logic signed [8:0] span_tc,         // signed span temp coefficient
  output logic signed [11:0] zero_tc,        // signed, scaled offset temp coeff
  output logic signed [10:0] sot_bridge,     // quadratic term on bridge
  output logic signed [10:0] sot_span_tc,    // quadratic term on span coeff
  output logic signed [10:0] sot_zero_tc,    // quadratic term on offset coeff
  output logic [5:0]        preamp_gain,     // preamplifier gain value
  input  wire logic         sample_valid,    // new corrected sample
  input  wire logic [13:0]  bridge_sample,   // corrected bridge value
  input  wire logic [7:0]   temp_sample,     // corrected temperature byte
  output logic              frame_valid,     // digital frame ready pulse
  output logic [1:0]        frame_len,       // digital frame byte count
  output logic [8:0]        frame_byte0,     // parity + bridge high
  output logic [8:0]        frame_byte1,     // parity + bridge low
  output logic [8:0]        frame_byte2      // parity + temperature
);

  // ====================
  // storage and working copy
  logic [15:0]          nv_mem_reg [0:`SCS_NV_WORDS-1];
  logic [16*`SCS_NV_WORDS-1:0] nv_flat;
  logic [`SCS_NV_BITS-1:0] wk_reg;
  scs_pkg::scs_state_t  state_reg;
  logic                 cmd_hit;
  logic [3:0]           cmd_field;
  logic [3:0]           cmd_data;
  scs_refresh_if        rif ();

  // field extraction from the working copy
  function automatic logic [15:0] scs_field(input logic [`SCS_NV_BITS-1:0] img,
                                            input int unsigned lsb);
    scs_field = img[lsb +: 16];
  endfunction

  // ====================
  // flatten storage words into one stored-bit image
  genvar gi;
  generate
    for (gi = 0; gi < `SCS_NV_WORDS; gi++) begin : g_flat
      assign nv_flat[16*gi +: 16] = nv_mem_reg[gi];
    end
  endgenerate

  // ====================
  // configuration command decode
  assign cmd_hit   = cmd_valid && (cmd_word[15:8] == `SCS_CMD_CFG_WRITE); // RQ21
  assign cmd_field = cmd_word[7:4];                                      // RQ21
  assign cmd_data  = cmd_word[3:0];

  // store writes; a word write in the same cycle wins over a command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `SCS_NV_WORDS; i++) begin
        nv_mem_reg[i] <= 16'h0000;
      end
      nv_mem_reg[0][15]  <= 1'(`SCS_RST_BSPAN);
      nv_mem_reg[1][13:0] <= 14'(`SCS_RST_BSPAN >> 1);
      nv_mem_reg[2][15:12] <= 4'(`SCS_RST_TSPAN);
      nv_mem_reg[3][3:0]   <= 4'(`SCS_RST_TSPAN >> 4);
      nv_mem_reg[6][1:0]   <= `SCS_RST_GAIN;
    end else if (coef_wr_valid && coef_wr_index < 3'(`SCS_NV_WORDS)) begin
      if (coef_wr_index == 3'h6) begin
        nv_mem_reg[coef_wr_index] <= {12'h000, coef_wr_data[3:0]};
      end else begin
        nv_mem_reg[coef_wr_index] <= coef_wr_data;
      end
    end else if (cmd_hit) begin
      if (cmd_field == `SCS_FLD_OSC) begin
        nv_mem_reg[0][`SCS_OSC_LSB +: 3] <= cmd_data[2:0];                // RQ21
      end else if (cmd_field == `SCS_FLD_VREF) begin
        nv_mem_reg[0][`SCS_VREF_LSB +: 4] <= cmd_data;
      end else if (cmd_field == `SCS_FLD_WINDOW) begin
        nv_mem_reg[0][`SCS_WIN_LSB +: 2] <= cmd_data[1:0];
      end else if (cmd_field == `SCS_FLD_OUTFMT) begin
        nv_mem_reg[0][`SCS_OUT_LSB +: 2] <= cmd_data[1:0];
      end else if (cmd_field == `SCS_FLD_RATE) begin
        nv_mem_reg[0][`SCS_RATE_LSB +: 2] <= cmd_data[1:0];
      end else if (cmd_field == `SCS_FLD_REG) begin
        nv_mem_reg[0][`SCS_REG_LSB +: 2] <= cmd_data[1:0];
      end else if (cmd_field == `SCS_FLD_TCOPT) begin
        nv_mem_reg[5][`SCS_TCOPT_LSB-80 +: 4] <= cmd_data;
      end else if (cmd_field == `SCS_FLD_ROUTE) begin
        nv_mem_reg[6][3:0] <= cmd_data;                                   // RQ19
      end
    end
  end

  // ====================
  // store readback, unused top bits of the last word read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (rd_index < 3'(`SCS_NV_WORDS)) begin
      rd_data <= nv_mem_reg[rd_index];
    end else begin
      rd_data <= 16'h0000;
    end
  end

  // ====================
  // load sequencer: copy the image once after reset, then on every tick.
  // settings stay stable inside a period so a conversion never sees a
  // half-written set of coefficients
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= scs_pkg::SCS_ST_LOAD;
      wk_reg    <= '0;
      cfg_ready <= 1'b0;
    end else begin
      case (state_reg)
        scs_pkg::SCS_ST_LOAD: begin
          wk_reg    <= nv_flat[`SCS_NV_BITS-1:0];                         // RQ22
          cfg_ready <= 1'b1;
          state_reg <= scs_pkg::SCS_ST_RUN;
        end
        scs_pkg::SCS_ST_RUN: begin
          if (rif.tick) begin
            wk_reg <= nv_flat[`SCS_NV_BITS-1:0];                          // RQ22
          end
        end
        default: begin
          state_reg <= scs_pkg::SCS_ST_LOAD;
        end
      endcase
    end
  end

  // ====================
  // refresh timer follows the working rate field
  assign rif.period_sel = wk_reg[`SCS_RATE_LSB +: 2];                     // RQ7
  assign refresh_tick   = rif.tick;

  scs_refresh_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .rif   (rif)
  );

  // ====================
  // oscillator, reference, window decode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_step    <= 4'sh0;
      vref_adjust <= 4'h0;
      window_low  <= -5'sh1;
    end else begin
      // code read as signed and negated: 100 -> +4 fastest, 011 -> -3 slowest
      osc_step    <= -4'(signed'(wk_reg[`SCS_OSC_LSB +: 3]));             // RQ1
      vref_adjust <= wk_reg[`SCS_VREF_LSB +: 4];
      case (wk_reg[`SCS_WIN_LSB +: 2])
        2'b11:   window_low <= -5'sh8;                                    // RQ2
        2'b10:   window_low <= -5'sh4;                                    // RQ2
        2'b01:   window_low <= -5'sh2;                                    // RQ2
        default: window_low <= -5'sh1;                                    // RQ2
      endcase
    end
  end

  // output format and regulator flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_digital      <= 1'b0;
      out_with_temp    <= 1'b0;
      out_analog_abs   <= 1'b0;
      out_analog_ratio <= 1'b0;
      reg_enable       <= 1'b0;
      reg_high         <= 1'b0;
      bridge_invert    <= 1'b0;
    end else begin
      case (scs_pkg::scs_outfmt_t'(wk_reg[`SCS_OUT_LSB +: 2]))
        scs_pkg::SCS_OUT_DIG3: begin
          out_digital      <= 1'b1;                                       // RQ4
          out_with_temp    <= 1'b1;
          out_analog_abs   <= 1'b0;
          out_analog_ratio <= 1'b0;
        end
        scs_pkg::SCS_OUT_ABS: begin
          out_digital      <= 1'b0;                                       // RQ5
          out_with_temp    <= 1'b0;
          out_analog_abs   <= 1'b1;
          out_analog_ratio <= 1'b0;
        end
        scs_pkg::SCS_OUT_RATIO: begin
          out_digital      <= 1'b0;                                       // RQ5
          out_with_temp    <= 1'b0;
          out_analog_abs   <= 1'b0;
          out_analog_ratio <= 1'b1;
        end
        default: begin
          out_digital      <= 1'b1;                                       // RQ6
          out_with_temp    <= 1'b0;
          out_analog_abs   <= 1'b0;
          out_analog_ratio <= 1'b0;
        end
      endcase
      reg_enable    <= wk_reg[`SCS_REG_LSB + 1];                          // RQ8
      reg_high      <= wk_reg[`SCS_REG_LSB + 1] && wk_reg[`SCS_REG_LSB];  // RQ8
      bridge_invert <= wk_reg[`SCS_TCOPT_LSB + 3];                        // RQ3
    end
  end

  // ====================
  // bridge and temperature coefficients
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      span_x8     <= 1'b0;
      span_frac   <= 14'h0000;
      bridge_zero <= 14'sh0000;
      temp_span   <= 8'h00;
      temp_zero   <= 8'h00;
      temp_ref    <= 8'h00;
    end else begin
      span_x8     <= wk_reg[`SCS_BSPAN_LSB + 14];                         // RQ9
      span_frac   <= 14'(scs_field(wk_reg, `SCS_BSPAN_LSB)); // RQ10
      bridge_zero <= signed'(14'(scs_field(wk_reg, `SCS_BZERO_LSB))); // RQ11
      temp_span   <= 8'(scs_field(wk_reg, `SCS_TSPAN_LSB)); // RQ12
      temp_zero   <= 8'(scs_field(wk_reg, `SCS_TZERO_LSB)); // RQ13
      temp_ref    <= 8'(scs_field(wk_reg, `SCS_TREF_LSB)); // RQ14
    end
  end

  // ====================
  // temperature coefficients with sign and scale options
  logic [3:0]  tc_opt;
  logic [7:0]  span_tc_mag;
  logic [10:0] zero_tc_mag;
  logic [9:0]  sot_mag;
  logic        sot_neg;
  logic [1:0]  sot_route;
  logic signed [10:0] sot_plain;
  logic signed [10:0] sot_to_zero;

  assign tc_opt      = wk_reg[`SCS_TCOPT_LSB +: 4];
  assign span_tc_mag = 8'(scs_field(wk_reg, `SCS_SPANTC_LSB));
  assign zero_tc_mag = tc_opt[1] ? {8'(scs_field(wk_reg, `SCS_ZEROTC_LSB)), 3'b000} // RQ17
                                 : {3'b000, 8'(scs_field(wk_reg, `SCS_ZEROTC_LSB))};
  assign sot_neg     = wk_reg[`SCS_SOT_LSB + 7];                          // RQ18
  assign sot_mag     = {3'b000, wk_reg[`SCS_SOT_LSB +: 7]};               // RQ18
  assign sot_route   = wk_reg[`SCS_ROUTE_LSB +: 2];
  assign sot_plain   = sot_neg ? -signed'({1'b0, sot_mag}) : signed'({1'b0, sot_mag});
  // the x8 scale only touches the term when it goes to the offset coefficient
  assign sot_to_zero = tc_opt[1] ? (sot_plain <<< 3) : sot_plain;         // RQ17

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      span_tc <= 9'sh000;
      zero_tc <= 12'sh000;
    end else begin
      span_tc <= tc_opt[2] ? -signed'({1'b0, span_tc_mag})                // RQ15
                           : signed'({1'b0, span_tc_mag});
      zero_tc <= tc_opt[0] ? -signed'({1'b0, zero_tc_mag})                // RQ16
                           : signed'({1'b0, zero_tc_mag});
    end
  end

  // ====================
  // quadratic term routing; the prohibited code routes it nowhere
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sot_bridge  <= 11'sh000;
      sot_span_tc <= 11'sh000;
      sot_zero_tc <= 11'sh000;
    end else begin
      sot_bridge  <= (sot_route == 2'b00) ? sot_plain : 11'sh000;         // RQ19
      sot_span_tc <= (sot_route == 2'b01) ? sot_plain : 11'sh000;         // RQ19
      sot_zero_tc <= (sot_route == 2'b10) ? sot_to_zero : 11'sh000;       // RQ19
    end
  end

  // ====================
  // preamplifier gain; only 24 is a guaranteed setting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preamp_gain <= 6'h18;
    end else begin
      case (wk_reg[`SCS_GAIN_LSB +: 2])
        2'b00:   preamp_gain <= 6'h06;                                    // RQ20
        2'b01:   preamp_gain <= 6'h18;                                    // RQ20
        2'b10:   preamp_gain <= 6'h0C;                                    // RQ20
        default: preamp_gain <= 6'h30;                                    // RQ20
      endcase
    end
  end

  // ====================
  // digital frame, built only while a digital format is active
  scs_frame_builder #(
    .PARITY_ODD (PARITY_ODD)
  ) u_frame (
    .clk         (clk),
    .rst_n       (rst_n),
    .load        (sample_valid && out_digital),                           // RQ4
    .with_temp   (out_with_temp),                                         // RQ6
    .bridge      (bridge_sample),
    .temp        (temp_sample),
    .frame_valid (frame_valid),
    .frame_len   (frame_len),
    .byte0       (frame_byte0),
    .byte1       (frame_byte1),
    .byte2       (frame_byte2)
  );

endmodule // scs_config_store

// >>> rtl/scs_frame_builder.sv
// digital output frame: bridge high, bridge low, optional temperature byte
`timescale 1ns/1ns
module scs_frame_builder #(
  parameter bit PARITY_ODD = 1'b0
) (
  input  wire logic        clk,         // system clock
  input  wire logic        rst_n,       // synchronous reset, active low
  input  wire logic        load,        // build a frame from the sample
  input  wire logic        with_temp,   // three bytes when set, two otherwise
  input  wire logic [13:0] bridge,      // corrected bridge value
  input  wire logic [7:0]  temp,        // corrected temperature byte
  output logic             frame_valid, // pulse when bytes are fresh
  output logic [1:0]       frame_len,   // number of bytes, 2 or 3
  output logic [8:0]       byte0,       // {parity, data} bridge high
  output logic [8:0]       byte1,       // {parity, data} bridge low
  output logic [8:0]       byte2        // {parity, data} temperature
);
  function automatic logic [8:0] scs_with_parity(input logic [7:0] d);
    scs_with_parity = {(^d) ^ PARITY_ODD, d};
  endfunction

  // ==================================================
  // register the bytes; the high byte carries two zero bits on top
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_valid <= 1'b0;
      frame_len   <= 2'h0;
      byte0       <= 9'h000;
      byte1       <= 9'h000;
      byte2       <= 9'h000;
    end else begin
      frame_valid <= load;
      if (load) begin
        byte0     <= scs_with_parity({2'b00, bridge[13:8]});
        byte1     <= scs_with_parity(bridge[7:0]);
        byte2     <= with_temp ? scs_with_parity(temp) : 9'h000;
        frame_len <= with_temp ? 2'h3 : 2'h2;
      end
    end
  end
endmodule // scs_frame_builder

// >>> rtl/scs_params.svh
// constants for the sensor conditioner configuration store
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// ==================================================
// configuration-write command
`define SCS_CMD_CFG_WRITE     8'h30
`define SCS_FLD_OSC           4'h0
`define SCS_FLD_VREF          4'h1
`define SCS_FLD_WINDOW        4'h2
`define SCS_FLD_OUTFMT        4'h3
`define SCS_FLD_RATE          4'h4
`define SCS_FLD_REG           4'h5
`define SCS_FLD_TCOPT         4'h6
`define SCS_FLD_ROUTE         4'h7

// ==================================================
// stored bit positions (low word layout of the first 15 bits is local)
`define SCS_OSC_LSB           0
`define SCS_VREF_LSB          3
`define SCS_WIN_LSB           7
`define SCS_OUT_LSB           9
`define SCS_RATE_LSB          11
`define SCS_REG_LSB           13
`define SCS_BSPAN_LSB         15
`define SCS_BZERO_LSB         30
`define SCS_TSPAN_LSB         44
`define SCS_TZERO_LSB         52
`define SCS_TREF_LSB          60
`define SCS_SPANTC_LSB        68
`define SCS_ZEROTC_LSB        76
`define SCS_TCOPT_LSB         84
`define SCS_SOT_LSB           88
`define SCS_GAIN_LSB          96
`define SCS_ROUTE_LSB         98
`define SCS_NV_BITS           100
`define SCS_NV_WORDS          7

// ==================================================
// reset values of the stored image
`define SCS_RST_BSPAN         15'h0800
`define SCS_RST_TSPAN         8'h80
`define SCS_RST_GAIN          2'h1

// ==================================================
// timing
`define SCS_CLK_MHZ           25
`define SCS_BASE_PERIOD_US    1000
`define SCS_PERIOD_MS_00      8'h01
`define SCS_PERIOD_MS_01      8'h05
`define SCS_PERIOD_MS_10      8'h19
`define SCS_PERIOD_MS_11      8'h7D

`endif

// >>> rtl/scs_pkg.sv
// types shared by the configuration store modules
package scs_pkg;

  // ==================================================
  // load sequencer states, one-hot
  typedef enum logic [1:0] {
    SCS_ST_LOAD = 2'b01,
    SCS_ST_RUN  = 2'b10
  } scs_state_t;

  // ==================================================
  // output format codes
  typedef enum logic [1:0] {
    SCS_OUT_DIG3  = 2'b00,
    SCS_OUT_ABS   = 2'b01,
    SCS_OUT_RATIO = 2'b10,
    SCS_OUT_DIG2  = 2'b11
  } scs_outfmt_t;

endpackage

// >>> rtl/scs_refresh_if.sv
// refresh period select and tick between store and timer
`timescale 1ns/1ns
interface scs_refresh_if;
  logic [1:0] period_sel;
  logic       tick;
  modport store (output period_sel, input tick);
  modport timer (input period_sel, output tick);
endinterface

// >>> rtl/scs_refresh_timer.sv
// update period timer: one-cycle tick per refresh period
`timescale 1ns/1ns
`include "scs_params.svh"
module scs_refresh_timer #(
  parameter int unsigned CYC_PER_MS = `SCS_CLK_MHZ * `SCS_BASE_PERIOD_US
) (
  input  wire logic  clk,   // system clock
  input  wire logic  rst_n, // synchronous reset, active low
  scs_refresh_if.timer rif  // period select in, tick out
);
  logic [15:0] cyc_reg;
  logic [7:0]  ms_reg;
  logic [7:0]  period_ms;
  logic        ms_pulse;

  // ==================================================
  // period decode in whole milliseconds
  always_comb begin
    case (rif.period_sel)
      2'b00:   period_ms = `SCS_PERIOD_MS_00;
      2'b01:   period_ms = `SCS_PERIOD_MS_01;
      2'b10:   period_ms = `SCS_PERIOD_MS_10;
      default: period_ms = `SCS_PERIOD_MS_11;
    endcase
  end

  assign ms_pulse = (cyc_reg == 16'(CYC_PER_MS - 1));

  // millisecond prescaler
  always_ff @(posedge clk) begin
    if (!rst_n || ms_pulse) begin
      cyc_reg <= 16'h0000;
    end else begin
      cyc_reg <= cyc_reg + 16'h0001;
    end
  end

  // period counter; a shorter period taking effect mid-count ends at the next millisecond
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ms_reg   <= 8'h00;
      rif.tick <= 1'b0;
    end else begin
      rif.tick <= 1'b0;
      if (ms_pulse) begin
        if (ms_reg >= period_ms - 8'h01) begin
          ms_reg   <= 8'h00;
          rif.tick <= 1'b1;
        end else begin
          ms_reg <= ms_reg + 8'h01;
        end
      end
    end
  end
endmodule // scs_refresh_timer
